// ---- hdl/pio_defs.svh ----
// offsets, field positions, reset values and nanosecond timings of the handshake card
`ifndef PIO_DEFS_SVH
`define PIO_DEFS_SVH

// ------------------------------------------------------------
// bus and data widths
// ------------------------------------------------------------
`define PIO_ADDR_W 12
`define PIO_DATA_W 16
`define PIO_CFG_W 9
`define PIO_STAT_W 8

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define PIO_OFF_CFG 12'h000
`define PIO_OFF_STAT 12'h004
`define PIO_OFF_IN 12'h008
`define PIO_OFF_OUT 12'h00c

// ------------------------------------------------------------
// option register fields
// ------------------------------------------------------------
`define PIO_CFG_CMD_LSB 0
`define PIO_CFG_RST_LSB 2
`define PIO_CFG_FEDGE_BIT 4
`define PIO_CFG_OGATE_BIT 5
`define PIO_CFG_IGATE_BIT 6
`define PIO_CFG_DMA_BIT 7
`define PIO_CFG_ASSOC_BIT 8
`define PIO_CFG_RESET 9'h040

// ------------------------------------------------------------
// status register fields
// ------------------------------------------------------------
`define PIO_ST_CMD_BIT 0
`define PIO_ST_CTRL_BIT 1
`define PIO_ST_FBUF_BIT 2
`define PIO_ST_FLAG_BIT 3
`define PIO_ST_ENC_BIT 4
`define PIO_ST_OE_BIT 5
`define PIO_ST_DFLAG_BIT 6
`define PIO_ST_PULSE_BIT 7

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define PIO_CLK_NS 5
`define PIO_PULSE_NS 1000

`endif

// ---- hdl/pio_edge_sync.sv ----
// three stage input synchroniser with agreement filter and edge events
`timescale 1ns/100ps

module pio_edge_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] stable_reg;
  logic [W-1:0] rise_reg;
  logic [W-1:0] fall_reg;

  // a change counts only once stages two and three agree
  wire [W-1:0] agree = ~(s2_reg ^ s3_reg);
  wire [W-1:0] change = agree & (s3_reg ^ stable_reg);
  wire [W-1:0] stable_next = (stable_reg & ~change) | (s3_reg & change);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      stable_reg <= '0;
      rise_reg <= '0;
      fall_reg <= '0;
    end else if (ce_i) begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      stable_reg <= stable_next;
      rise_reg <= change & s3_reg;
      fall_reg <= change & ~s3_reg;
    end
  end

  assign level_o = stable_reg;
  assign rise_o = rise_reg;
  assign fall_o = fall_reg;

endmodule : pio_edge_sync

// ---- hdl/pio_pkg.sv ----
// types shared by the handshake card modules
package pio_pkg;

  // jumper style option positions
  typedef enum logic [1:0] {
    PIO_OPT_A,
    PIO_OPT_B,
    PIO_OPT_C
  } pio_opt_e;

endpackage : pio_pkg

// ---- hdl/pio_pulse.sv ----
// retriggerable fixed length pulse with end event
`timescale 1ns/100ps

module pio_pulse #(
  parameter int CYCLES = 200
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_reg;
  logic done_reg;

  wire busy = (cnt_reg != '0);
  wire last = (cnt_reg == CW'(1));

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end else if (ce_i) begin
      if (start_i) begin
        cnt_reg <= CW'(CYCLES);
      end else if (busy) begin
        cnt_reg <= cnt_reg - CW'(1);
      end
      done_reg <= last & ~start_i;
    end
  end

  assign busy_o = busy;
  assign done_o = done_reg;

endmodule : pio_pulse

// ---- hdl/pio_top.sv ----
// parallel handshake card: host strobes, device handshake, apb option and status registers
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "pio_defs.svh"

// How it works
// - 16-bit storage registers; set-control sets command, driving encode to device.
// - set-control also sets control; interrupts only while control is set.
// - clear-flag resets flag buffer and flag, blocking early interrupts.
// - encode option: A level active low, B level active high, C low pulse.
// - device flag resets command: A rising, B falling, C at pulse end.
// - device flag sets flag buffer: A rising edge, B falling edge.
// - command reset edge and flag set edge are chosen independently.
// - gated input captures on flag buffer set while flag is tied to input; otherwise follows input lines.
// - device flag leads to skip condition or interrupt request toward host.
// - at T2 flag-enable with flag buffer set sets flag.
// - set flag raises interrupt unless higher priority device requests.
// - input-read strobe gates input register onto host input bus.
// - host tests flag through skip-if-set and skip-if-clear.
// - output-write at T4 loads output register, presented to device.
// - output lines change straight from old to new value.
// - output gating A drives data as set-control pulse; B drives always.
// - dma option A: control-clear or bus reset clear command; B: bus reset only.
// - flag logic tied to input register or output register, never both.
module pio_top
  import pio_pkg::*;
#(
  parameter int PULSE_CYCLES = (`PIO_PULSE_NS + `PIO_CLK_NS - 1) / `PIO_CLK_NS
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`PIO_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic t2_i,
  input wire logic t4_i,
  input wire logic set_control_strobe_i,
  input wire logic clear_flag_strobe_i,
  input wire logic control_clear_strobe_i,
  input wire logic bus_reset_strobe_i,
  input wire logic flag_enable_strobe_i,
  input wire logic input_read_strobe_i,
  input wire logic output_write_strobe_i,
  input wire logic skip_if_flag_set_i,
  input wire logic skip_if_flag_clear_i,
  input wire logic higher_prio_req_i,
  input wire logic [`PIO_DATA_W-1:0] host_output_data_bus_i,
  output logic [`PIO_DATA_W-1:0] host_input_data_bus_o,
  output logic skip_condition_o,
  output logic irq_o,
  input wire logic device_flag_i,
  input wire logic [`PIO_DATA_W-1:0] dev_data_i,
  output logic device_command_o,
  output logic [`PIO_DATA_W-1:0] dev_data_o,
  output logic dev_data_oe_o
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic pio_opt_e to_opt(input logic [1:0] code);
    pio_opt_e opt;
    opt = PIO_OPT_C;
    case (code)
      2'h0: opt = PIO_OPT_A;
      2'h1: opt = PIO_OPT_B;
      default: opt = PIO_OPT_C;
    endcase
    return opt;
  endfunction : to_opt

  function automatic logic addr_hit(input logic [`PIO_ADDR_W-1:0] addr,
                                    input logic [`PIO_ADDR_W-1:0] off);
    return addr == off;
  endfunction : addr_hit

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic cmd_reg;
  logic ctrl_reg;
  logic fbuf_reg;
  logic flag_reg;
  logic enc_reg;
  logic oe_reg;
  logic [`PIO_DATA_W-1:0] in_reg;
  logic [`PIO_DATA_W-1:0] out_reg;
  logic [`PIO_CFG_W-1:0] cfg_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic cmd_next;
  logic ctrl_next;
  logic fbuf_next;
  logic flag_next;
  logic enc_next;

  // ------------------------------------------------------------
  // option decode
  // ------------------------------------------------------------
  wire pio_opt_e cmd_opt = to_opt(cfg_reg[`PIO_CFG_CMD_LSB +: 2]);
  wire pio_opt_e rst_opt = to_opt(cfg_reg[`PIO_CFG_RST_LSB +: 2]);
  wire fedge_fall = cfg_reg[`PIO_CFG_FEDGE_BIT];
  wire ogate_cont = cfg_reg[`PIO_CFG_OGATE_BIT];
  wire igate_on = cfg_reg[`PIO_CFG_IGATE_BIT];
  wire dma_keep = cfg_reg[`PIO_CFG_DMA_BIT];
  wire assoc_out = cfg_reg[`PIO_CFG_ASSOC_BIT];

  // ------------------------------------------------------------
  // device inputs
  // ------------------------------------------------------------
  logic dflag_level;
  logic dflag_rise;
  logic dflag_fall;
  logic [`PIO_DATA_W-1:0] ddata_level;
  logic pulse_busy;
  logic pulse_done;

  pio_edge_sync #(
    .W(1)
  ) u_flag_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .async_i(device_flag_i),
    .level_o(dflag_level),
    .rise_o(dflag_rise),
    .fall_o(dflag_fall)
  );

  pio_edge_sync #(
    .W(`PIO_DATA_W)
  ) u_data_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .async_i(dev_data_i),
    .level_o(ddata_level),
    .rise_o(),
    .fall_o()
  );

  // command pulse for party-line modes
  pio_pulse #(
    .CYCLES(PULSE_CYCLES)
  ) u_pulse (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .start_i(set_control_strobe_i),
    .busy_o(pulse_busy),
    .done_o(pulse_done)
  );

  // ------------------------------------------------------------
  // handshake events
  // ------------------------------------------------------------
  wire fbuf_evt = fedge_fall ? dflag_fall : dflag_rise;
  wire edge_a_rst = (rst_opt == PIO_OPT_A) & dflag_rise;
  wire edge_b_rst = (rst_opt == PIO_OPT_B) & dflag_fall;
  wire pulse_rst = (rst_opt == PIO_OPT_C) & pulse_done;
  wire cmd_rst_evt = edge_a_rst | edge_b_rst | pulse_rst;
  wire clc_clears_cmd = control_clear_strobe_i & ~dma_keep;
  wire flag_set_evt = t2_i & flag_enable_strobe_i & fbuf_reg;
  wire out_load = t4_i & output_write_strobe_i;
  // flag logic serves one register only
  wire in_capture = (igate_on & ~assoc_out) ? fbuf_evt : 1'b1;

  // ------------------------------------------------------------
  // flip-flop next values
  // ------------------------------------------------------------
  always_comb begin
    cmd_next = cmd_reg;
    if (bus_reset_strobe_i) begin
      cmd_next = 1'b0;
    end else if (set_control_strobe_i) begin
      cmd_next = 1'b1;
    end else if (clc_clears_cmd | cmd_rst_evt) begin
      cmd_next = 1'b0;
    end
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    if (bus_reset_strobe_i) begin
      ctrl_next = 1'b0;
    end else if (set_control_strobe_i) begin
      ctrl_next = 1'b1;
    end else if (control_clear_strobe_i) begin
      ctrl_next = 1'b0;
    end
  end

  // set wins over clear-flag in the same cycle; bus reset wins over both
  always_comb begin
    fbuf_next = fbuf_reg;
    if (bus_reset_strobe_i) begin
      fbuf_next = 1'b0;
    end else if (fbuf_evt) begin
      fbuf_next = 1'b1;
    end else if (clear_flag_strobe_i) begin
      fbuf_next = 1'b0;
    end
  end

  always_comb begin
    flag_next = flag_reg;
    if (bus_reset_strobe_i) begin
      flag_next = 1'b0;
    end else if (flag_set_evt) begin
      flag_next = 1'b1;
    end else if (clear_flag_strobe_i) begin
      flag_next = 1'b0;
    end
  end

  // encode pin level per option
  always_comb begin
    case (cmd_opt)
      PIO_OPT_A: enc_next = ~cmd_reg;
      PIO_OPT_B: enc_next = cmd_reg;
      PIO_OPT_C: enc_next = ~(cmd_reg & pulse_busy);
      default: enc_next = ~cmd_reg;
    endcase
  end

  wire oe_next = ogate_cont | pulse_busy;

  // ------------------------------------------------------------
  // handshake flip-flops
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cmd_reg <= 1'b0;
      ctrl_reg <= 1'b0;
      fbuf_reg <= 1'b0;
      flag_reg <= 1'b0;
      enc_reg <= 1'b1;
      oe_reg <= 1'b0;
    end else if (ce_i) begin
      cmd_reg <= cmd_next;
      ctrl_reg <= ctrl_next;
      fbuf_reg <= fbuf_next;
      flag_reg <= flag_next;
      enc_reg <= enc_next;
      oe_reg <= oe_next;
    end
  end

  // ------------------------------------------------------------
  // storage registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      in_reg <= '0;
      out_reg <= '0;
    end else if (ce_i) begin
      if (in_capture) begin
        in_reg <= ddata_level;
      end
      if (out_load) begin
        out_reg <= host_output_data_bus_i;
      end
    end
  end

  // ------------------------------------------------------------
  // host side outputs
  // ------------------------------------------------------------
  wire svc_req = flag_reg & ctrl_reg;
  wire skip_set = skip_if_flag_set_i & flag_reg;
  wire skip_clr = skip_if_flag_clear_i & ~flag_reg;

  assign irq_o = svc_req & ~higher_prio_req_i;
  assign skip_condition_o = skip_set | skip_clr;
  assign host_input_data_bus_o = input_read_strobe_i ? in_reg : '0;

  // ------------------------------------------------------------
  // device side outputs
  // ------------------------------------------------------------
  assign device_command_o = enc_reg;
  assign dev_data_o = out_reg;
  assign dev_data_oe_o = oe_reg;

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  wire hit_cfg = addr_hit(paddr_i, `PIO_OFF_CFG);
  wire hit_stat = addr_hit(paddr_i, `PIO_OFF_STAT);
  wire hit_in = addr_hit(paddr_i, `PIO_OFF_IN);
  wire hit_out = addr_hit(paddr_i, `PIO_OFF_OUT);
  wire hit_any = hit_cfg | hit_stat | hit_in | hit_out;
  wire apb_setup = psel_i & ~penable_i;
  wire cfg_write = psel_i & penable_i & pwrite_i & hit_cfg;

  logic [`PIO_STAT_W-1:0] status;
  always_comb begin
    status = '0;
    status[`PIO_ST_CMD_BIT] = cmd_reg;
    status[`PIO_ST_CTRL_BIT] = ctrl_reg;
    status[`PIO_ST_FBUF_BIT] = fbuf_reg;
    status[`PIO_ST_FLAG_BIT] = flag_reg;
    status[`PIO_ST_ENC_BIT] = enc_reg;
    status[`PIO_ST_OE_BIT] = oe_reg;
    status[`PIO_ST_DFLAG_BIT] = dflag_level;
    status[`PIO_ST_PULSE_BIT] = pulse_busy;
  end

  wire [31:0] rd_cfg = {{(32 - `PIO_CFG_W){1'b0}}, cfg_reg};
  wire [31:0] rd_stat = {{(32 - `PIO_STAT_W){1'b0}}, status};
  wire [31:0] rd_in = {{(32 - `PIO_DATA_W){1'b0}}, in_reg};
  wire [31:0] rd_out = {{(32 - `PIO_DATA_W){1'b0}}, out_reg};
  wire [31:0] rd_mux = hit_cfg ? rd_cfg :
                       hit_stat ? rd_stat :
                       hit_in ? rd_in :
                       hit_out ? rd_out : 32'h0000_0000;

  // read data and error are sampled in setup so the access phase needs no wait
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cfg_reg <= `PIO_CFG_RESET;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (ce_i) begin
      if (cfg_write) begin
        cfg_reg <= pwdata_i[`PIO_CFG_W-1:0];
      end
      if (apb_setup) begin
        prdata_reg <= pwrite_i ? 32'h0000_0000 : rd_mux;
        pslverr_reg <= ~hit_any;
      end
    end
  end

  assign pready_o = ce_i;
  assign prdata_o = prdata_reg;
  assign pslverr_o = pslverr_reg & psel_i & penable_i;

endmodule : pio_top

// ---- test/pio_dev_model.sv ----
// far end device: answers an encode with a data word and a flag pulse
`timescale 1ns/100ps
module pio_dev_model #(
  parameter int DELAY = 3,
  parameter int HOLD = 8
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic cmd_act_i,
  input wire logic [15:0] word_i,
  output logic flag_o,
  output logic [15:0] data_o
);
  int cnt;
  logic busy;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt <= 0;
      busy <= 1'b0;
      flag_o <= 1'b0;
      data_o <= 16'h0000;
    end else if (!busy) begin
      cnt <= cmd_act_i ? cnt + 1 : 0;
      if (cnt == DELAY) begin
        busy <= 1'b1;
        cnt <= 0;
        flag_o <= 1'b1;
        data_o <= word_i;
      end
    end else begin
      cnt <= cnt + 1;
      if (cnt == HOLD) flag_o <= 1'b0;
      // data runs out after its hold time
      if (cnt == 2 * HOLD) data_o <= ~data_o;
      if (cnt > 2 * HOLD && !cmd_act_i) busy <= 1'b0;
    end
  end
endmodule : pio_dev_model

// ---- test/pio_top_props.sv ----
// assertion checker for the handshake card host and device ports
`timescale 1ns/100ps
`include "pio_defs.svh"
module pio_top_props (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic t2_i,
  input wire logic t4_i,
  input wire logic set_control_strobe_i,
  input wire logic clear_flag_strobe_i,
  input wire logic bus_reset_strobe_i,
  input wire logic flag_enable_strobe_i,
  input wire logic input_read_strobe_i,
  input wire logic output_write_strobe_i,
  input wire logic skip_if_flag_set_i,
  input wire logic skip_if_flag_clear_i,
  input wire logic higher_prio_req_i,
  input wire logic [`PIO_DATA_W-1:0] host_output_data_bus_i,
  input wire logic [`PIO_DATA_W-1:0] host_input_data_bus_o,
  input wire logic skip_condition_o,
  input wire logic irq_o,
  input wire logic [`PIO_DATA_W-1:0] dev_data_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i || !ce_i);
  sequence s_load;
    output_write_strobe_i && t4_i;
  endsequence
  sequence s_arm;
    $rose(irq_o) && !$fell(higher_prio_req_i) && !$past(set_control_strobe_i);
  endsequence
  a_irq_prio: assert property (irq_o |-> !higher_prio_req_i)
    else $error("irq while higher priority requests");
  a_flag_t2: assert property (s_arm |-> $past(flag_enable_strobe_i && t2_i))
    else $error("flag set without flag enable at t2");
  a_clf_quiet: assert property (
    clear_flag_strobe_i && !(flag_enable_strobe_i && t2_i) |=> !irq_o)
    else $error("irq after clear flag");
  a_crs_idle: assert property (bus_reset_strobe_i |=> !irq_o [*2])
    else $error("irq after bus reset");
  a_out_load: assert property (s_load |=> dev_data_o == $past(host_output_data_bus_i))
    else $error("output register not loaded at t4");
  a_out_hold: assert property (!(output_write_strobe_i && t4_i) |=> $stable(dev_data_o))
    else $error("output lines moved without load");
  a_read_gate: assert property (!input_read_strobe_i |-> host_input_data_bus_o == '0)
    else $error("input bus driven without read strobe");
  a_skip_poll: assert property (irq_o && skip_if_flag_set_i |-> skip_condition_o)
    else $error("skip missing on set flag");
  a_skip_none: assert property (
    !skip_if_flag_set_i && !skip_if_flag_clear_i |-> !skip_condition_o)
    else $error("skip without test");
endmodule : pio_top_props

bind pio_top pio_top_props pio_top_props_inst (.*);

// ---- test/testbench.sv ----
// self-checking bench for the parallel handshake card
`timescale 1ns/100ps
`include "pio_defs.svh"
module testbench;
  typedef struct packed {
    logic [8:0] cfg;
    logic act;
    logic [15:0] ow;
    logic [15:0] iw;
  } pio_row_s;
  localparam pio_row_s ROWS [6] = '{
    '{9'h040, 1'b0, 16'ha5c3, 16'h3c5a},
    '{9'h065, 1'b1, 16'h0001, 16'hfffe},
    '{9'h050, 1'b0, 16'h8000, 16'h7fff},
    '{9'h00a, 1'b0, 16'h0ff0, 16'h5aa5},
    '{9'h140, 1'b0, 16'hc001, 16'h0f0f},
    '{9'h0f5, 1'b1, 16'h1234, 16'hedcb}};
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [`PIO_ADDR_W-1:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, rd;
  logic pready_o, pslverr_o, er;
  logic [8:0] hs = '0;
  logic sks = 1'b0, skc = 1'b0, hpr = 1'b0, mdl_en = 1'b0, act = 1'b0;
  logic [15:0] hob = '0, wd = '0, hib, dd, ddo;
  logic cmd, dflag, oe, skip, irq;
  logic ce = 1'b1;
  logic [15:0] ein;
  wire logic cmd_act = mdl_en && (cmd === act);
  int num_errors = 0, compares = 0;

  pio_top #(.PULSE_CYCLES(4)) pio_top_inst (.clk_i, .srst_i, .ce_i(ce), .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .t2_i(hs[7]),
    .t4_i(hs[8]), .set_control_strobe_i(hs[0]), .clear_flag_strobe_i(hs[1]),
    .control_clear_strobe_i(hs[2]), .bus_reset_strobe_i(hs[3]),
    .flag_enable_strobe_i(hs[4]), .input_read_strobe_i(hs[5]),
    .output_write_strobe_i(hs[6]), .skip_if_flag_set_i(sks), .skip_if_flag_clear_i(skc),
    .higher_prio_req_i(hpr), .host_output_data_bus_i(hob), .host_input_data_bus_o(hib),
    .skip_condition_o(skip), .irq_o(irq), .device_flag_i(dflag), .dev_data_i(ddo),
    .device_command_o(cmd), .dev_data_o(dd), .dev_data_oe_o(oe));
  pio_dev_model pio_dev_model_inst (.clk_i, .srst_i, .cmd_act_i(cmd_act), .word_i(wd),
    .flag_o(dflag), .data_o(ddo));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic pulse(input logic [8:0] v);
    hs <= v;
    cyc(1);
    hs <= '0;
    cyc(1);
  endtask : pulse

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    cyc(1);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    cyc(1);
  endtask : apb

  task automatic test_done;
    if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  initial begin
    #50000;
    num_errors++;
    test_done;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cyc(10);
    srst_i <= 1'b0;
    cyc(1);
    apb(1'b0, `PIO_OFF_CFG, 32'h0);
    cmp(rd, 32'h40);
    apb(1'b1, `PIO_OFF_STAT, 32'hff);
    apb(1'b0, `PIO_OFF_STAT, 32'h0);
    cmp(rd, 32'h10);
    apb(1'b0, 12'h010, 32'h0);
    cmp({rd[30:0], er}, 32'h1);
    foreach (ROWS[i]) begin
      mdl_en <= 1'b0;
      act <= ROWS[i].act;
      wd <= ROWS[i].iw;
      hob <= ROWS[i].ow;
      apb(1'b1, `PIO_OFF_CFG, {23'h0, ROWS[i].cfg});
      mdl_en <= 1'b1;
      pulse(9'h140);
      pulse(9'h003);
      @(negedge clk_i);
      cmp(cmd, ROWS[i].act);
      cmp(oe, 1'b1);
      cyc(1);
      hs <= 9'h090;
      sks <= 1'b1;
      for (int n = 0; n < 99 && skip !== 1'b1; n++) @(negedge clk_i);
      cmp(skip, 1'b1);
      cmp(irq, 1'b1);
      cyc(1);
      hpr <= 1'b1;
      @(negedge clk_i);
      cmp(irq, 1'b0);
      cyc(1);
      hpr <= 1'b0;
      for (int n = 0; n < 99 && cmd !== !ROWS[i].act; n++) @(negedge clk_i);
      cmp(cmd, !ROWS[i].act);
      cmp(oe, ROWS[i].cfg[5]);
      cmp(dd, ROWS[i].ow);
      cyc(1);
      hs <= 9'h020;
      @(negedge clk_i);
      cmp(hib, ROWS[i].iw);
      cyc(1);
      hs <= '0;
      sks <= 1'b0;
      cyc(1);
      pulse(9'h002);
      @(negedge clk_i);
      cmp(irq, 1'b0);
      cyc(20);
      apb(1'b0, `PIO_OFF_IN, 32'h0);
      ein = ROWS[i].cfg[6] && !ROWS[i].cfg[8] ? ROWS[i].iw : ~ROWS[i].iw;
      cmp(rd, {16'h0, ein});
    end
    mdl_en <= 1'b0;
    hob <= 16'hffff;
    pulse(9'h040);
    apb(1'b0, `PIO_OFF_OUT, 32'h0);
    cmp(rd, 32'h1234);
    pulse(9'h001);
    pulse(9'h004);
    @(negedge clk_i);
    cmp(cmd, 1'b1);
    cyc(1);
    apb(1'b1, `PIO_OFF_CFG, 32'h75);
    pulse(9'h004);
    @(negedge clk_i);
    cmp(cmd, 1'b0);
    cyc(1);
    pulse(9'h001);
    pulse(9'h008);
    cyc(6);
    apb(1'b0, `PIO_OFF_STAT, 32'h0);
    cmp(rd, 32'h20);
    cmp(irq, 1'b0);
    skc <= 1'b1;
    @(negedge clk_i);
    cmp(skip, 1'b1);
    cyc(1);
    skc <= 1'b0;
    ce <= 1'b0;
    pulse(9'h001);
    ce <= 1'b1;
    cyc(1);
    @(negedge clk_i);
    cmp(cmd, 1'b0);
    test_done;
  end
endmodule : testbench
